// [rtl/srg_pkg.sv]
package shift_rotate_pkg;

	localparam int INSTR_W = 16;
	localparam int ADDR_W = 9;
	localparam int WORD_W = 24;
	localparam int DEC_W = 4;
	localparam int ROM_IDX_W = 2;

	// control store locations, idle at 0 and octal 100..104, written in hex
	localparam logic [ADDR_W-1:0] LOC_IDLE = 9'h000;
	localparam logic [ADDR_W-1:0] LOC_A_START = 9'h040;
	localparam logic [ADDR_W-1:0] LOC_A_SKIP = 9'h041;
	localparam logic [ADDR_W-1:0] LOC_A_LOWER = 9'h042;
	localparam logic [ADDR_W-1:0] LOC_A_TAIL = 9'h043;
	localparam logic [ADDR_W-1:0] LOC_B_START = 9'h044;

	// microwords: octal 07777117, 07777777, 07777135, 77777777
	localparam logic [WORD_W-1:0] WORD_A_START = 24'h1ffe4f;
	localparam logic [WORD_W-1:0] WORD_A_SKIP = 24'h1fffff;
	localparam logic [WORD_W-1:0] WORD_A_LOWER = 24'h1ffe5d;
	localparam logic [WORD_W-1:0] WORD_A_TAIL = 24'hffffff;

	localparam logic [ROM_IDX_W-1:0] IDX_START = 2'h0;
	localparam logic [ROM_IDX_W-1:0] IDX_SKIP = 2'h1;
	localparam logic [ROM_IDX_W-1:0] IDX_LOWER = 2'h2;
	localparam logic [ROM_IDX_W-1:0] IDX_TAIL = 2'h3;

	// instruction word fields
	localparam int GRP_HI = 15;
	localparam int GRP_LO = 12;
	localparam logic [3:0] GRP_CODE = 4'h0;
	localparam int ALTER_BIT = 10;
	localparam int AB_BIT = 11;
	localparam int UPPER_HI = 9;
	localparam int UPPER_LO = 6;
	localparam int LOWER_HI = 2;
	localparam int LOWER_LO = 0;
	localparam int LOWER_EXTRA = 4;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_SHIFT1 = 5'h02,
		ST_SKIP = 5'h04,
		ST_SHIFT2 = 5'h08,
		ST_TAIL = 5'h10
	} seq_state_e;

endpackage : shift_rotate_pkg

// [rtl/microword_rom.sv]
`timescale 1ns/1ns
module microword_rom
	import shift_rotate_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [ROM_IDX_W-1:0] idx_i,
	output logic [WORD_W-1:0] word_o
);

	// read data registered so the word lines up with the sequencer state
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			word_o <= WORD_A_TAIL;
		end else begin
			unique case (idx_i)
				IDX_START: word_o <= WORD_A_START;
				IDX_SKIP: word_o <= WORD_A_SKIP;
				IDX_LOWER: word_o <= WORD_A_LOWER;
				IDX_TAIL: word_o <= WORD_A_TAIL;
			endcase
		end
	end

endmodule : microword_rom

// [rtl/shift_rotate_a_microroutine.sv]
// What this block does
// RQ1: shift-rotate instructions dispatch to the A routine or the B routine
// RQ2: first decode code gates instruction bits 6 to 9 into the decoder
// RQ3: second decode code gates instruction bits 0 to 2 and 4
// RQ4: A-side shift-rotates and no-op start at location 100, run 100 to 103
// RQ5: at 100 gate upper bits, A onto R-bus, shift, store back into A
// RQ6: at 101 A passes R-bus and function generator for skip testing
// RQ7: at 102 gate lower bits, shift A, store A, end the phase
// RQ8: location 103 does nothing beyond the default function field
// RQ9: word at location 100 is octal 07777117
// RQ10: first decode code also sets the shift-active flag
// RQ11: locations 100 to 103 step one per cycle without branching
`timescale 1ns/1ns
module shift_rotate_a_microroutine
	import shift_rotate_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic dispatch_i,
	input wire logic [INSTR_W-1:0] instr_i,
	output logic [ADDR_W-1:0] routine_addr_o,
	output logic [WORD_W-1:0] micro_word_o,
	output logic busy_o,
	output logic b_routine_start_o,
	output logic upper_bits_decode_gate_o,
	output logic lower_bits_decode_gate_o,
	output logic [DEC_W-1:0] decode_operand_o,
	output logic shift_active_flag_o,
	output logic rbus_sel_a_o,
	output logic fn_ior_o,
	output logic store_a_o,
	output logic skip_test_o,
	output logic end_of_phase_o
);

	seq_state_e state;
	seq_state_e next_state;
	logic [INSTR_W-1:0] ir;
	logic [ROM_IDX_W-1:0] next_idx;
	logic take_a;
	logic take_b;

	function automatic logic is_group(input logic [INSTR_W-1:0] w);
		return (w[GRP_HI:GRP_LO] == GRP_CODE) && !w[ALTER_BIT];
	endfunction : is_group

	function automatic logic [DEC_W-1:0] lower_bits(input logic [INSTR_W-1:0] w);
		return {w[LOWER_EXTRA], w[LOWER_HI:LOWER_LO]};
	endfunction : lower_bits

	function automatic logic [ADDR_W-1:0] state_addr(input seq_state_e s);
		logic [ADDR_W-1:0] a;
		a = LOC_IDLE;
		unique case (s)
			ST_IDLE: a = LOC_IDLE;
			ST_SHIFT1: a = LOC_A_START;
			ST_SKIP: a = LOC_A_SKIP;
			ST_SHIFT2: a = LOC_A_LOWER;
			ST_TAIL: a = LOC_A_TAIL;
		endcase
		return a;
	endfunction : state_addr

	// the no-op word is all zero, so it falls into the A-side group
	assign take_a = (state == ST_IDLE) && dispatch_i && is_group(instr_i)
		&& !instr_i[AB_BIT]; // [RQ1] [RQ4]
	assign take_b = (state == ST_IDLE) && dispatch_i && is_group(instr_i)
		&& instr_i[AB_BIT]; // [RQ1]

	// straight-line stepping, no branch inside the routine
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (take_a) begin
					next_state = ST_SHIFT1; // [RQ4]
				end
			end
			ST_SHIFT1: next_state = ST_SKIP; // [RQ11]
			ST_SKIP: next_state = ST_SHIFT2; // [RQ11]
			ST_SHIFT2: next_state = ST_TAIL; // [RQ11]
			ST_TAIL: next_state = ST_IDLE; // [RQ11]
		endcase
	end

	always_comb begin
		next_idx = IDX_TAIL;
		unique case (next_state)
			ST_IDLE: next_idx = IDX_TAIL;
			ST_SHIFT1: next_idx = IDX_START;
			ST_SKIP: next_idx = IDX_SKIP;
			ST_SHIFT2: next_idx = IDX_LOWER;
			ST_TAIL: next_idx = IDX_TAIL;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// instruction held for the whole routine; the register outside may move on
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ir <= '0;
		end else if (take_a) begin
			ir <= instr_i;
		end
	end

	microword_rom u_rom (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.idx_i(next_idx),
		.word_o(micro_word_o)
	); // [RQ9]

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			routine_addr_o <= LOC_IDLE;
			busy_o <= 1'b0;
		end else begin
			routine_addr_o <= state_addr(next_state);
			busy_o <= (next_state != ST_IDLE);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			b_routine_start_o <= 1'b0;
		end else begin
			b_routine_start_o <= take_b; // [RQ1]
		end
	end

	// decoder gates; the upper operand comes from the live port at dispatch, the lower operand from the held copy
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			upper_bits_decode_gate_o <= 1'b0;
			lower_bits_decode_gate_o <= 1'b0;
			decode_operand_o <= '0;
		end else begin
			upper_bits_decode_gate_o <= (next_state == ST_SHIFT1); // [RQ2] [RQ5]
			lower_bits_decode_gate_o <= (next_state == ST_SHIFT2); // [RQ3] [RQ7]
			if (next_state == ST_SHIFT1) begin
				decode_operand_o <= instr_i[UPPER_HI:UPPER_LO]; // [RQ2]
			end else if (next_state == ST_SHIFT2) begin
				decode_operand_o <= lower_bits(ir); // [RQ3]
			end else begin
				decode_operand_o <= '0;
			end
		end
	end

	// set wins: entering 100 always sets, clear only when the routine ends
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			shift_active_flag_o <= 1'b0;
		end else if (next_state == ST_SHIFT1) begin
			shift_active_flag_o <= 1'b1; // [RQ10]
		end else if (next_state == ST_IDLE) begin
			shift_active_flag_o <= 1'b0;
		end
	end

	// datapath controls; the shifter result is latched into A by store_a_o
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rbus_sel_a_o <= 1'b0;
			fn_ior_o <= 1'b0;
			store_a_o <= 1'b0;
		end else begin
			rbus_sel_a_o <= (next_state == ST_SHIFT1) || (next_state == ST_SKIP)
				|| (next_state == ST_SHIFT2); // [RQ5] [RQ6] [RQ7]
			fn_ior_o <= (next_state != ST_IDLE); // [RQ6] [RQ8]
			store_a_o <= (next_state == ST_SHIFT1)
				|| (next_state == ST_SHIFT2); // [RQ5] [RQ7] [RQ8]
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			skip_test_o <= 1'b0;
			end_of_phase_o <= 1'b0;
		end else begin
			skip_test_o <= (next_state == ST_SKIP); // [RQ6]
			end_of_phase_o <= (next_state == ST_SHIFT2); // [RQ7]
		end
	end

	// checks
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	sequence walk_s;
		(routine_addr_o == LOC_A_START) ##1 (routine_addr_o == LOC_A_SKIP)
		##1 (routine_addr_o == LOC_A_LOWER) ##1 (routine_addr_o == LOC_A_TAIL)
		##1 (routine_addr_o == LOC_IDLE);
	endsequence

	sequence a_taken_s;
		(state == ST_IDLE) && dispatch_i && is_group(instr_i) && !instr_i[AB_BIT];
	endsequence

	sequence b_taken_s;
		(state == ST_IDLE) && dispatch_i && is_group(instr_i) && instr_i[AB_BIT];
	endsequence

	dispatch_a_a: assert property (a_taken_s |=> walk_s) // [RQ4]
		else $error("A routine did not run 100 to 103 in order");

	// back-to-back B hand-offs are legal, so a second cycle is fine if it was dispatched
	dispatch_b_a: assert property (b_taken_s |=> b_routine_start_o && !busy_o // [RQ1]
		##1 (!b_routine_start_o || $past(take_b)))
		else $error("B routine start not a single pulse");

	b_start_src_a: assert property (b_routine_start_o // [RQ1]
		|-> $past(take_b) && !busy_o)
		else $error("B routine start without a B-side dispatch");

	step_order_a: assert property ((routine_addr_o == LOC_A_SKIP) // [RQ11]
		|-> $past(routine_addr_o) == LOC_A_START)
		else $error("location 101 not preceded by 100");

	skip_next_a: assert property (skip_test_o |=> lower_bits_decode_gate_o) // [RQ11]
		else $error("location 102 does not follow 101");

	busy_span_a: assert property ($rose(busy_o) |-> busy_o [*4] ##1 !busy_o) // [RQ11]
		else $error("routine length is not four cycles");

	upper_gate_a: assert property (upper_bits_decode_gate_o // [RQ2]
		|-> routine_addr_o == LOC_A_START && rbus_sel_a_o && store_a_o
		&& decode_operand_o == ir[UPPER_HI:UPPER_LO])
		else $error("upper decode gate wrong at 100");

	lower_gate_a: assert property ((routine_addr_o == LOC_A_LOWER) // [RQ3]
		|-> lower_bits_decode_gate_o && !upper_bits_decode_gate_o
		&& decode_operand_o == lower_bits(ir))
		else $error("lower decode gate wrong at 102");

	lower_step_a: assert property (lower_bits_decode_gate_o // [RQ7]
		|-> end_of_phase_o && store_a_o && rbus_sel_a_o)
		else $error("location 102 does not shift, store and end the phase");

	gate_exclusive_a: assert property (!(upper_bits_decode_gate_o // [RQ2] [RQ3]
		&& lower_bits_decode_gate_o))
		else $error("both decode gates open at once");

	ir_hold_a: assert property ((busy_o && !upper_bits_decode_gate_o) // [RQ3]
		|-> $stable(ir))
		else $error("held instruction changed inside the routine");

	sequence store_pair_s;
		store_a_o && (routine_addr_o == LOC_A_START) ##1 !store_a_o
		##1 store_a_o && (routine_addr_o == LOC_A_LOWER) ##1 !store_a_o;
	endsequence

	store_a_a: assert property (upper_bits_decode_gate_o |-> store_pair_s) // [RQ5]
		else $error("A store not at 100 and 102");

	store_place_a: assert property (store_a_o // [RQ8]
		|-> (routine_addr_o == LOC_A_START) || (routine_addr_o == LOC_A_LOWER))
		else $error("A store outside 100 and 102");

	skip_test_a: assert property (skip_test_o |-> rbus_sel_a_o && fn_ior_o // [RQ6]
		&& !store_a_o && routine_addr_o == LOC_A_SKIP)
		else $error("skip test step malformed");

	end_phase_a: assert property (end_of_phase_o |-> store_a_o // [RQ7]
		&& $past(skip_test_o) ##1 !end_of_phase_o)
		else $error("end of phase not at 102");

	quiet_tail_a: assert property ((routine_addr_o == LOC_A_TAIL) // [RQ8]
		|-> fn_ior_o && !store_a_o && !rbus_sel_a_o && !end_of_phase_o
		&& decode_operand_o == '0)
		else $error("location 103 has activity");

	start_word_a: assert property ((routine_addr_o == LOC_A_START) // [RQ9]
		|-> micro_word_o == WORD_A_START)
		else $error("word at 100 is not 07777117");

	sequence word_walk_s;
		(micro_word_o == WORD_A_START) ##1 (micro_word_o == WORD_A_SKIP)
		##1 (micro_word_o == WORD_A_LOWER) ##1 (micro_word_o == WORD_A_TAIL);
	endsequence

	words_walk_a: assert property ((routine_addr_o == LOC_A_START) |-> word_walk_s) // [RQ9]
		else $error("microwords at 100 to 103 out of order");

	flag_set_a: assert property (upper_bits_decode_gate_o // [RQ10]
		|-> shift_active_flag_o ##1 shift_active_flag_o)
		else $error("shift-active flag not set by first decode code");

	flag_clear_a: assert property ((routine_addr_o == LOC_A_TAIL) |=> !shift_active_flag_o) // [RQ10]
		else $error("shift-active flag not cleared after the routine");

	idle_quiet_a: assert property (!busy_o |-> routine_addr_o == LOC_IDLE // [RQ4]
		&& !rbus_sel_a_o && !fn_ior_o && !store_a_o && !skip_test_o && !end_of_phase_o
		&& !shift_active_flag_o && decode_operand_o == '0)
		else $error("datapath controls active while idle");

endmodule : shift_rotate_a_microroutine

// [sim/srg_sequencer_model.sv]
`timescale 1ns/1ns
module sequencer_model
	import shift_rotate_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic req_i,
	input wire logic [INSTR_W-1:0] word_i,
	output logic dispatch_o = 1'b0,
	output logic [INSTR_W-1:0] instr_o = '0
);
	// the word is only valid while dispatch is offered; otherwise it keeps
	// toggling so a design that samples it late sees garbage
	always @(posedge sys_clk_i) begin
		dispatch_o <= req_i;
		if (req_i) begin
			instr_o <= word_i;
		end else begin
			instr_o <= ~instr_o;
		end
	end
endmodule : sequencer_model

// [sim/shift_rotate_a_microroutine_tb_top.sv]
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module shift_rotate_a_microroutine_tb_top
	import shift_rotate_pkg::*;
;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic req = 1'b0;
	logic [INSTR_W-1:0] word = '0;
	logic dispatch;
	logic [INSTR_W-1:0] instr;
	logic [ADDR_W-1:0] routine_addr_o;
	logic [WORD_W-1:0] micro_word_o;
	logic [DEC_W-1:0] decode_operand_o;
	logic busy_o, b_start, up_g, lo_g, flag, rb_a, ior, st_a, skip, eop;
	int errors = 0;
	int check_count = 0;
	logic [ADDR_W-1:0] addr_tbl [5] = '{LOC_A_START, LOC_A_SKIP, LOC_A_LOWER, LOC_A_TAIL, LOC_IDLE};
	logic [WORD_W-1:0] word_tbl [5] = '{24'h1ffe4f, WORD_A_SKIP, WORD_A_LOWER, WORD_A_TAIL, 24'hffffff};
	// {busy, upper, lower, flag, rbus a, ior, store a, skip, eop}
	logic [8:0] flag_tbl [5] = '{9'h1bc, 9'h13a, 9'h17d, 9'h128, 9'h000};

	always #5 sys_clk_i = ~sys_clk_i;

	sequencer_model i_seq (.sys_clk_i(sys_clk_i), .req_i(req), .word_i(word),
		.dispatch_o(dispatch), .instr_o(instr));

	shift_rotate_a_microroutine i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.dispatch_i(dispatch), .instr_i(instr), .routine_addr_o(routine_addr_o),
		.micro_word_o(micro_word_o), .busy_o(busy_o), .b_routine_start_o(b_start),
		.upper_bits_decode_gate_o(up_g), .lower_bits_decode_gate_o(lo_g),
		.decode_operand_o(decode_operand_o), .shift_active_flag_o(flag), .rbus_sel_a_o(rb_a),
		.fn_ior_o(ior), .store_a_o(st_a), .skip_test_o(skip), .end_of_phase_o(eop));

	task results;
		if (errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results

	task offer(input logic [INSTR_W-1:0] w);
		@(posedge sys_clk_i);
		req <= 1'b1;
		word <= w;
		@(posedge sys_clk_i) req <= 1'b0;
	endtask : offer

	// bounded wait for busy (on_b = 0) or the b-side hand-off pulse (on_b = 1)
	task wait_for(input bit on_b);
		for (int i = 0; i < 8; i++) begin
			@(negedge sys_clk_i);
			if ((on_b ? b_start : busy_o) === 1'b1) return;
		end
		`CHK("wait", 1'b1, 1'b0)
		results();
	endtask : wait_for

	// checks locations 100..103 and the idle cycle after, one per cycle
	task walk(input logic [INSTR_W-1:0] w);
		logic [DEC_W-1:0] dec;
		for (int i = 0; i < 5; i++) begin
			dec = (i == 0) ? w[UPPER_HI:UPPER_LO] :
				(i == 2) ? {w[LOWER_EXTRA], w[LOWER_HI:LOWER_LO]} : 4'h0;
			`CHK("addr", addr_tbl[i], routine_addr_o)
			`CHK("word", word_tbl[i], micro_word_o)
			`CHK("ctl", flag_tbl[i], {busy_o, up_g, lo_g, flag, rb_a, ior, st_a, skip, eop})
			`CHK("decode", dec, decode_operand_o)
			`CHK("b_start", 1'b0, b_start)
			@(negedge sys_clk_i);
		end
	endtask : walk

	task a_run(input logic [INSTR_W-1:0] w);
		offer(w);
		wait_for(1'b0);
		walk(w);
	endtask : a_run

	task b_run(input logic [INSTR_W-1:0] w);
		offer(w);
		wait_for(1'b1);
		`CHK("busy_b", 1'b0, busy_o)
		@(negedge sys_clk_i);
		`CHK("b_pulse", 1'b0, b_start)
	endtask : b_run

	task no_take(input logic [INSTR_W-1:0] w);
		offer(w);
		repeat (6) begin
			@(negedge sys_clk_i);
			`CHK("busy_ng", 1'b0, busy_o)
			`CHK("b_ng", 1'b0, b_start)
		end
	endtask : no_take

	// dispatch held high: ignored while busy, taken again right after the idle cycle
	task back_to_back(input logic [INSTR_W-1:0] w);
		@(posedge sys_clk_i);
		req <= 1'b1;
		word <= w;
		wait_for(1'b0);
		walk(w);
		fork
			@(posedge sys_clk_i) req <= 1'b0;
		join_none
		walk(w);
	endtask : back_to_back

	initial begin
		repeat (16) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(negedge sys_clk_i);
		`CHK("rst_word", 24'hffffff, micro_word_o)
		`CHK("rst_busy", 1'b0, busy_o)
		a_run(16'h0155);
		a_run(16'h0000);
		a_run(16'h02aa);
		b_run(16'h0955);
		b_run(16'h0bff);
		no_take(16'h1155);
		no_take(16'h0555);
		back_to_back(16'h03c7);
		results();
	end
endmodule : shift_rotate_a_microroutine_tb_top
